// [rtl/bsc_pkg.sv]
package bsc_pkg;

   // timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int BBM_TIME_NS = 40;
   localparam int BBM_CYCLES = (BBM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BBM_CNT_W = 4;

   // register map, byte addresses
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] TCC_OFFSET = 8'h00;
   localparam logic [APB_AW-1:0] STATUS_OFFSET = 8'h04;

   // reset values
   localparam logic [7:0] TCC_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h02;

   // charge control fields
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 4;
   localparam int DIODE_MSB = 3;
   localparam int DIODE_LSB = 2;
   localparam int RES_MSB = 1;
   localparam int RES_LSB = 0;
   localparam logic [3:0] CHARGE_KEY = 4'ha;
   localparam logic [1:0] DIODE_NONE = 2'h2;
   localparam logic [1:0] DIODE_TWO = 2'h1;
   localparam logic [1:0] RES_1K7 = 2'h2;
   localparam logic [1:0] RES_2K9 = 2'h1;
   localparam logic [1:0] RES_5K = 2'h3;
   localparam logic [1:0] RES_OFF = 2'h0;

   // status fields
   localparam int ST_BACKUP = 0;
   localparam int ST_SEALED = 1;
   localparam int ST_OUT_MAIN = 2;
   localparam int ST_OUT_BACKUP = 3;
   localparam int ST_CHARGING = 4;
   localparam int ST_CMP_LSB = 5;
   localparam int ST_BACKUP_SEEN = 8;

   typedef enum logic [2:0] {
      SW_SEALED = 3'h0,
      SW_MAIN = 3'h1,
      SW_OPEN_TO_BACKUP = 3'h3,
      SW_BACKUP = 3'h7,
      SW_OPEN_TO_MAIN = 3'h5
   } bsc_sw_state_t;

   typedef struct packed {
      logic above_backup_supply;
      logic above_tpd;
      logic above_rst;
   } bsc_cmp_t;

   typedef struct packed {
      logic charge_en;
      logic diode_none;
      logic diode_two;
      logic res_1k7;
      logic res_2k9;
      logic res_5k;
   } bsc_charge_t;

   typedef struct packed {
      logic manual_reset_in_n;
      logic watchdog_kick_in;
      logic chip_enable_in_n;
      logic sda_in;
   } bsc_ctl_in_t;

endpackage

// [rtl/bsc_sync2.sv]
`timescale 1ns/1ps
module bsc_sync2
   import bsc_pkg::*;
#(
   parameter int W = 3
) (
   input wire logic clk_sys_i, // system clock
   input wire logic sys_rst_i, // async reset, active high
   input wire logic [W-1:0] async_i, // raw levels
   output logic [W-1:0] sync_o // synchronised levels
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } bsc_sync_state_t;

   bsc_sync_state_t s;
   bsc_sync_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.stage1 = async_i;
      next_s.stage2 = s.stage1;
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign sync_o = s.stage2;

endmodule

// [rtl/bsc_charge_dec.sv]
`timescale 1ns/1ps
module bsc_charge_dec
   import bsc_pkg::*;
(
   input wire logic [7:0] ctrl_i, // charge control register
   output bsc_charge_t dec_o // decoded charger setting, before supply gating
);

   function automatic bsc_charge_t decode(input logic [7:0] v);
      bsc_charge_t d;
      logic [1:0] dio;
      logic [1:0] res;
      d = '0;
      dio = v[DIODE_MSB:DIODE_LSB];
      res = v[RES_MSB:RES_LSB];
      // key guards against a stray write turning the charger on
      if (v[KEY_MSB:KEY_LSB] == CHARGE_KEY && (dio == DIODE_NONE || dio == DIODE_TWO)
          && res != RES_OFF) begin
         d.charge_en = 1'b1;
         d.diode_none = (dio == DIODE_NONE);
         d.diode_two = (dio == DIODE_TWO);
         d.res_1k7 = (res == RES_1K7);
         d.res_2k9 = (res == RES_2K9);
         d.res_5k = (res == RES_5K);
      end
      return d;
   endfunction

   assign dec_o = decode(ctrl_i);

endmodule

// [rtl/bsc_top.sv]
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Summary of operation
// - Run from the main supply above the reset threshold and from backup only when below both the reset threshold and the switch point.
// - While the reset outputs are active, manual reset, watchdog, chip enable and serial inputs are ignored.
// - In backup mode both resets and power-fail stay active, the piezo floats and chip-enable out is pulled high.
// - In backup mode timekeeping keeps running and alarm and crystal-fail detection run when enabled.
// - With only the backup supply ever applied the device stays sealed and idle until the main supply first passes the reset threshold.
// - The charger is forced off whenever the main supply is below the backup supply.
// - The charger runs only with key 1010 in bits 7:4, a diode code of 10 or 01 and a nonzero resistor code.
// - The diode code 10 means no diode and 01 two diodes; the resistor code 10 is 1.7K, 01 is 2.9K and 11 is 5K.
// - The switched supply follows main when main is above the reset threshold or the backup voltage, else backup, breaking before making.
// - All registers hold their reset values until the power-on reset is released.
// - In backup mode the manual reset, watchdog, chip enable and power-fail inputs are ignored and piezo and serial data are off.
// - The charger comes out of power-on reset disabled.
module bsc_top
   import bsc_pkg::*;
#(
   parameter int BBM_WAIT = BBM_CYCLES
) (
   input wire logic clk_sys_i, // system clock, 125 MHz
   input wire logic sys_rst_i, // power-on reset, async, active high
   // apb slave
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [APB_AW-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped address
   // supply comparators, raw
   input wire bsc_cmp_t cmp_i, // main above reset threshold / switch point / backup
   // supervisor and pin side
   input wire logic sup_reset_i, // reset timer still running, active high
   input wire bsc_ctl_in_t ctl_in_i, // raw control inputs
   input wire logic power_fail_in_i, // power-fail comparator tripped, active high
   input wire logic chip_enable_in_n_i, // chip-enable from host, active low
   input wire logic piezo_drive_i, // piezo tone from divider
   input wire logic sda_drive_low_i, // serial block pulls data low
   input wire logic alarm_in_i, // alarm match, active high
   input wire logic crystal_fail_in_i, // crystal fault seen, active high
   input wire logic alarm_detect_req_i, // alarm detection enabled by software
   input wire logic xtal_detect_req_i, // crystal-fail detection enabled
   output bsc_ctl_in_t ctl_gated_o, // control inputs after gating
   output logic reset_n_o, // reset, active low
   output logic reset_o, // reset, active high
   output logic power_fail_out_n_o, // power-fail, active low
   output logic chip_enable_out_n_o, // gated chip-enable, active low
   output logic piezo_out_o, // piezo level
   output logic piezo_oe_n_o, // piezo enable, low drives
   output logic sda_o, // serial data out level
   output logic sda_oe_n_o, // serial data enable, low drives
   output logic backup_active_flag_o, // running from backup
   output logic alarm_out_o, // alarm, active high
   output logic crystal_fail_out_o, // crystal fail, active high
   output logic timekeep_run_o, // timekeeping counters run
   output logic alarm_detect_en_o, // alarm detection runs
   output logic xtal_detect_en_o, // crystal-fail detection runs
   output logic sw_main_o, // switched supply tied to main
   output logic sw_backup_o, // switched supply tied to backup
   output bsc_charge_t charge_o // charger controls
);

   typedef struct packed {
      bsc_sw_state_t sw;
      logic [BBM_CNT_W-1:0] bbm_cnt;
      logic sealed;
      logic backup;
      logic backup_seen;
      logic [7:0] tcc;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      bsc_charge_t charge;
      bsc_ctl_in_t gated;
      logic rst_n;
      logic rst;
      logic pfo_n;
      logic ce_out_n;
      logic piezo_out;
      logic pzt_oe_n;
      logic sda;
      logic sda_oe_n;
      logic alarm;
      logic xfail;
      logic tk_run;
      logic alm_en;
      logic xf_en;
      logic sw_main;
      logic sw_backup;
   } bsc_state_t;

   localparam logic [BBM_CNT_W-1:0] BBM_LAST = BBM_CNT_W'(BBM_WAIT - 1);

   bsc_state_t s;
   bsc_state_t next_s;
   bsc_cmp_t cmp;
   bsc_charge_t charge_dec;
   logic [2:0] cmp_raw;
   logic [2:0] cmp_sync;

   function automatic logic addr_hit(input logic [APB_AW-1:0] a,
                                     input logic [APB_AW-1:0] off);
      return a == off;
   endfunction

   function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
      return addr_hit(a, TCC_OFFSET) | addr_hit(a, STATUS_OFFSET);
   endfunction

   // status shows the synced comparator levels, the ones the power mode acts on
   function automatic logic [31:0] read_word(input logic [APB_AW-1:0] a,
                                             input bsc_state_t st,
                                             input bsc_cmp_t c);
      logic [31:0] w;
      w = '0;
      if (addr_hit(a, TCC_OFFSET)) begin
         w[7:0] = st.tcc;
      end else if (addr_hit(a, STATUS_OFFSET)) begin
         w[ST_BACKUP] = st.backup;
         w[ST_SEALED] = st.sealed;
         w[ST_OUT_MAIN] = st.sw_main;
         w[ST_OUT_BACKUP] = st.sw_backup;
         w[ST_CHARGING] = st.charge.charge_en;
         w[ST_CMP_LSB +: 3] = c;
         w[ST_BACKUP_SEEN] = st.backup_seen;
      end
      return w;
   endfunction

   assign cmp_raw = cmp_i;
   assign cmp = cmp_sync;

   bsc_sync2 #(
      .W(3)
   ) u_cmp_sync (
      .clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i),
      .async_i(cmp_raw),
      .sync_o(cmp_sync)
   );

   bsc_charge_dec u_charge_dec (
      .ctrl_i(s.tcc),
      .dec_o(charge_dec)
   );

   always_comb begin
      logic want_main;
      logic go_backup;
      logic force_idle;
      logic access;
      logic wr_done;
      logic [31:0] rd;
      logic mapped;
      logic charge_ok;
      want_main = 1'b0;
      go_backup = 1'b0;
      force_idle = 1'b0;
      access = 1'b0;
      wr_done = 1'b0;
      rd = '0;
      mapped = 1'b0;
      charge_ok = 1'b0;
      next_s = s;

      // switched supply follows main above threshold or above backup
      want_main = cmp.above_rst | cmp.above_backup_supply;
      // backup only when below both threshold and switch point
      go_backup = ~cmp.above_rst & ~cmp.above_tpd;

      // one-shot unseal on the first real main supply
      if (s.sealed && cmp.above_rst) begin
         next_s.sealed = 1'b0;
      end

      // gray loop: main, open, backup, open, main
      case (s.sw)
         SW_SEALED: begin
            if (cmp.above_rst) begin
               next_s.sw = SW_MAIN;
            end
         end
         SW_MAIN: begin
            if (!want_main) begin
               next_s.sw = SW_OPEN_TO_BACKUP;
               next_s.bbm_cnt = '0;
            end
         end
         SW_OPEN_TO_BACKUP, SW_OPEN_TO_MAIN: begin
            // both switches open for the whole gap, then pick the live side
            if (s.bbm_cnt >= BBM_LAST) begin
               next_s.sw = want_main ? SW_MAIN : SW_BACKUP;
               next_s.bbm_cnt = '0;
            end else begin
               next_s.bbm_cnt = s.bbm_cnt + 1'b1;
            end
         end
         SW_BACKUP: begin
            if (want_main) begin
               next_s.sw = SW_OPEN_TO_MAIN;
               next_s.bbm_cnt = '0;
            end
         end
         default: begin
            next_s.sw = SW_SEALED;
            next_s.bbm_cnt = '0;
         end
      endcase

      // enables follow the next state, so both drop together at the break
      next_s.sw_main = (next_s.sw == SW_MAIN);
      next_s.sw_backup = (next_s.sw == SW_BACKUP);

      // sealed part never claims backup mode, so it draws nothing
      next_s.backup = ~next_s.sealed & go_backup;
      force_idle = next_s.sealed | next_s.backup;

      // reset outputs held active in backup and while sealed
      next_s.rst = force_idle | sup_reset_i;
      next_s.rst_n = ~next_s.rst;
      // power-fail forced active and its input ignored in backup
      next_s.pfo_n = force_idle ? 1'b0 : ~power_fail_in_i;
      // chip-enable pulled to the switched supply, gated by reset too
      next_s.ce_out_n = next_s.rst ? 1'b1 : chip_enable_in_n_i;

      // inputs drop to their idle levels while reset is active
      if (next_s.rst) begin
         next_s.gated.manual_reset_in_n = 1'b1;
         next_s.gated.watchdog_kick_in = 1'b0;
         next_s.gated.chip_enable_in_n = 1'b1;
         next_s.gated.sda_in = 1'b1;
      end else begin
         next_s.gated = ctl_in_i;
      end
      if (next_s.backup) begin
         next_s.gated.manual_reset_in_n = 1'b1;
         next_s.gated.watchdog_kick_in = 1'b0;
         next_s.gated.chip_enable_in_n = 1'b1;
      end

      // piezo floats in backup
      next_s.piezo_out = force_idle ? 1'b0 : piezo_drive_i;
      next_s.pzt_oe_n = force_idle ? 1'b1 : 1'b0;
      // open-drain data: only ever drives low, released in backup
      next_s.sda = 1'b0;
      next_s.sda_oe_n = (force_idle | next_s.rst) ? 1'b1 : ~sda_drive_low_i;

      // these keep working from backup, only the sealed part is silent
      next_s.alarm = ~next_s.sealed & alarm_in_i;
      next_s.xfail = ~next_s.sealed & crystal_fail_in_i;
      next_s.tk_run = ~next_s.sealed;
      next_s.alm_en = ~next_s.sealed & alarm_detect_req_i;
      next_s.xf_en = ~next_s.sealed & xtal_detect_req_i;

      // charger gated by the supply, whatever software wrote
      charge_ok = cmp.above_backup_supply & ~force_idle;
      if (charge_dec.charge_en && charge_ok) begin
         next_s.charge = charge_dec;
      end else begin
         next_s.charge = '0;
      end

      // apb: one wait state so read data leaves a flop
      access = psel & penable;
      next_s.pready = access & ~s.pready;
      wr_done = access & s.pready & pwrite;
      if (access && !s.pready) begin
         mapped = addr_mapped(paddr);
         rd = read_word(paddr, s, cmp);
         next_s.prdata = pwrite ? 32'h0000_0000 : rd;
         next_s.pslverr = ~mapped;
      end else if (!access) begin
         next_s.prdata = '0;
         next_s.pslverr = 1'b0;
      end

      if (wr_done && addr_hit(paddr, TCC_OFFSET)) begin
         next_s.tcc = pwdata[7:0];
      end

      // sticky record of any backup episode, write one to clear
      if (wr_done && addr_hit(paddr, STATUS_OFFSET) && pwdata[ST_BACKUP_SEEN]) begin
         next_s.backup_seen = 1'b0;
      end
      // a new backup entry beats a clear in the same cycle
      if (next_s.backup) begin
         next_s.backup_seen = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '0;
         s.sw <= SW_SEALED;
         s.sealed <= 1'b1;
         s.tcc <= TCC_RESET;
         s.charge <= '0;
         // bus answers nothing until the reset lets go
         s.pready <= 1'b0;
         s.pslverr <= 1'b0;
         s.prdata <= '0;
         s.rst <= 1'b1;
         s.rst_n <= 1'b0;
         s.pfo_n <= 1'b0;
         s.ce_out_n <= 1'b1;
         s.pzt_oe_n <= 1'b1;
         s.sda_oe_n <= 1'b1;
         s.gated.manual_reset_in_n <= 1'b1;
         s.gated.chip_enable_in_n <= 1'b1;
         s.gated.sda_in <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign ctl_gated_o = s.gated;
   assign reset_n_o = s.rst_n;
   assign reset_o = s.rst;
   assign power_fail_out_n_o = s.pfo_n;
   assign chip_enable_out_n_o = s.ce_out_n;
   assign piezo_out_o = s.piezo_out;
   assign piezo_oe_n_o = s.pzt_oe_n;
   assign sda_o = s.sda;
   assign sda_oe_n_o = s.sda_oe_n;
   assign backup_active_flag_o = s.backup;
   assign alarm_out_o = s.alarm;
   assign crystal_fail_out_o = s.xfail;
   assign timekeep_run_o = s.tk_run;
   assign alarm_detect_en_o = s.alm_en;
   assign xtal_detect_en_o = s.xf_en;
   assign sw_main_o = s.sw_main;
   assign sw_backup_o = s.sw_backup;
   assign charge_o = s.charge;

endmodule

// [tb/bsc_supply_model.sv]
`timescale 1ns/1ps
module bsc_supply_model
   import bsc_pkg::*;
(
   input wire logic [2:0] mode_i, // supply condition
   output bsc_cmp_t cmp_o // comparator levels
);
   // 0 battery only, 1 main up, 2 brownout above switch point, 3 main gone,
   // 4 main up but under battery; levels are {backup_supply,tpd,rst}
   always_comb begin
      case (mode_i)
         3'h1: cmp_o = 3'h7;
         3'h2: cmp_o = 3'h6;
         3'h4: cmp_o = 3'h3;
         default: cmp_o = 3'h0;
      endcase
   end
endmodule

// [tb/bsc_top_sva.sv]
`timescale 1ns/1ps
module bsc_top_sva
   import bsc_pkg::*;
#(
   parameter int BBM_WAIT = BBM_CYCLES
) (
   input wire logic clk_sys_i, // clock
   input wire logic sys_rst_i, // reset
   input wire bsc_cmp_t cmp_i, // raw levels
   input wire bsc_ctl_in_t ctl_gated_o, // gated inputs
   input wire logic reset_n_o, // reset low
   input wire logic reset_o, // reset high
   input wire logic power_fail_out_n_o, // power fail
   input wire logic chip_enable_out_n_o, // ce out
   input wire logic piezo_oe_n_o, // piezo enable
   input wire logic sda_oe_n_o, // data enable
   input wire logic backup_active_flag_o, // backup
   input wire logic alarm_in_i, // alarm in
   input wire logic alarm_out_o, // alarm out
   input wire logic sw_main_o, // main switch
   input wire logic sw_backup_o, // backup switch
   input wire bsc_charge_t charge_o // charger
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic [7:0] open_cnt;
   logic seen_main;
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         open_cnt <= 8'h00;
         seen_main <= 1'b0;
      end else begin
         open_cnt <= (!sw_main_o && !sw_backup_o) ? open_cnt + 8'h01 : 8'h00;
         seen_main <= seen_main | cmp_i.above_rst;
      end
   end
   property p_excl; !(sw_main_o && sw_backup_o); endproperty
   a_excl: assert property (p_excl) else $error("both switches closed");
   property p_bbm; $rose(sw_backup_o) |-> open_cnt == BBM_WAIT; endproperty
   a_bbm: assert property (p_bbm) else $error("break time wrong");
   property p_bkp; backup_active_flag_o |-> reset_o && !reset_n_o && !power_fail_out_n_o
      && piezo_oe_n_o && chip_enable_out_n_o && sda_oe_n_o; endproperty
   a_bkp: assert property (p_bkp) else $error("backup outputs");
   property p_gate; reset_o |-> ctl_gated_o == 4'hb && chip_enable_out_n_o; endproperty
   a_gate: assert property (p_gate) else $error("inputs pass in reset");
   property p_sel; $rose(backup_active_flag_o) |->
      $past(!cmp_i.above_rst && !cmp_i.above_tpd, 3); endproperty
   a_sel: assert property (p_sel) else $error("backup without cause");
   property p_main; cmp_i.above_rst [*3] |=> !backup_active_flag_o; endproperty
   a_main: assert property (p_main) else $error("backup with main up");
   property p_chg; charge_o.charge_en |-> $past(cmp_i.above_backup_supply, 3) && !backup_active_flag_o
      && (charge_o.diode_none ^ charge_o.diode_two)
      && $onehot({charge_o.res_1k7, charge_o.res_2k9, charge_o.res_5k}); endproperty
   a_chg: assert property (p_chg) else $error("charger on wrongly");
   property p_seal; !seen_main |-> reset_o && !sw_main_o && !sw_backup_o; endproperty
   a_seal: assert property (p_seal) else $error("left seal early");
   property p_alm; backup_active_flag_o && $past(backup_active_flag_o) |->
      alarm_out_o == $past(alarm_in_i); endproperty
   a_alm: assert property (p_alm) else $error("alarm lost in backup");
endmodule
bind bsc_top bsc_top_sva #(.BBM_WAIT(BBM_WAIT)) bsc_top_sva_inst (.clk_sys_i, .sys_rst_i,
   .cmp_i, .ctl_gated_o, .reset_n_o, .reset_o, .power_fail_out_n_o, .chip_enable_out_n_o,
   .piezo_oe_n_o, .sda_oe_n_o, .backup_active_flag_o, .alarm_in_i, .alarm_out_o, .sw_main_o,
   .sw_backup_o, .charge_o);

// [tb/bsc_top_tb_top.sv]
`timescale 1ns/1ps
module bsc_top_tb_top
   import bsc_pkg::*;
;
   localparam int BW = 5;
   logic clk_sys_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, perr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0] mode;
   bsc_cmp_t cmp;
   bsc_ctl_in_t ctl_in, ctl_g;
   bsc_charge_t chg;
   logic sup_rst, pf_in, ce_in_n, pz, sda_lo, alarm_out, xf, alm_req, xf_req;
   logic rst_n, rst, pfo_n, ce_n, pz_o, pz_oe_n, sda, sda_oe_n, bkp, alm_o, xf_o;
   logic tk, alm_en, xf_en, sw_m, sw_b;
   int bad_count, samples_checked, n, cyc_cnt;
   logic [7:0] tv [10] = '{8'haa, 8'ha9, 8'hab, 8'ha6, 8'ha5, 8'ha7, 8'ha2, 8'hae, 8'ha8, 8'hba};
   logic [5:0] te [10] = '{6'h34, 6'h32, 6'h31, 6'h2c, 6'h2a, 6'h29, 6'h0, 6'h0, 6'h0, 6'h0};

   bsc_supply_model bsc_supply_model_inst (.mode_i(mode), .cmp_o(cmp));
   bsc_top #(.BBM_WAIT(BW)) bsc_top_inst (.clk_sys_i, .sys_rst_i, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .cmp_i(cmp), .sup_reset_i(sup_rst),
      .ctl_in_i(ctl_in), .power_fail_in_i(pf_in), .chip_enable_in_n_i(ce_in_n),
      .piezo_drive_i(pz), .sda_drive_low_i(sda_lo), .alarm_in_i(alarm_out), .crystal_fail_in_i(xf),
      .alarm_detect_req_i(alm_req), .xtal_detect_req_i(xf_req), .ctl_gated_o(ctl_g),
      .reset_n_o(rst_n), .reset_o(rst), .power_fail_out_n_o(pfo_n),
      .chip_enable_out_n_o(ce_n), .piezo_out_o(pz_o), .piezo_oe_n_o(pz_oe_n), .sda_o(sda),
      .sda_oe_n_o(sda_oe_n), .backup_active_flag_o(bkp), .alarm_out_o(alm_o),
      .crystal_fail_out_o(xf_o), .timekeep_run_o(tk), .alarm_detect_en_o(alm_en),
      .xtal_detect_en_o(xf_en), .sw_main_o(sw_m), .sw_backup_o(sw_b), .charge_o(chg));

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge clk_sys_i) begin
      cyc_cnt++;
      if (cyc_cnt > 20000) begin
         bad_count++;
         results();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask

   // one idle cycle after each transfer keeps psel from being driven twice at one edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys_i);
      end while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   // 0 backup flag, 1 backup switch, 2 main switch; a hang runs into the bench timeout
   task automatic wait_for(input int sel);
      n = 0;
      while ((sel == 0 ? bkp : (sel == 1 ? sw_b : sw_m)) !== 1'b1) begin
         @(posedge clk_sys_i);
         n++;
      end
   endtask

   initial begin
      {psel, penable, pwrite, paddr, pwdata, mode} = '0;
      {sup_rst, pf_in, pz, sda_lo, alarm_out, xf, alm_req, xf_req} = '0;
      ce_in_n = 1'b1;
      ctl_in = 4'h4;
      sys_rst_i = 1'b1;
      cyc(10);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      apb(1'b0, TCC_OFFSET, 32'h0);
      chk(rd, {24'h0, TCC_RESET});
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd, {24'h0, STATUS_RESET});
      apb(1'b0, 8'h08, 32'h0);
      chk(perr, 1'b1);
      cyc(20);
      chk({rst, sw_m, sw_b, bkp, tk}, 5'h10);
      $display("test seal done");
      mode <= 3'h1;
      cyc(10);
      chk({sw_m, bkp, tk}, 3'h5);
      sup_rst <= 1'b1;
      ce_in_n <= 1'b0;
      cyc(3);
      chk({rst, ctl_g, ce_n}, 6'h37);
      sup_rst <= 1'b0;
      cyc(3);
      chk({rst, ctl_g, ce_n}, 6'h08);
      $display("test gating done");
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, TCC_OFFSET, {24'h0, tv[i]});
         cyc(2);
         if (te[i][5])
            chk(chg, te[i]);
         else
            chk(chg.charge_en, 1'b0);
         apb(1'b0, TCC_OFFSET, 32'h0);
         chk(rd, {24'h0, tv[i]});
      end
      apb(1'b1, TCC_OFFSET, 32'haa);
      mode <= 3'h4;
      cyc(4);
      chk(chg.charge_en, 1'b0);
      mode <= 3'h2;
      cyc(4);
      chk({sw_m, bkp, chg.charge_en}, 3'h5);
      $display("test charger done");
      {alarm_out, xf, pz, sda_lo, alm_req, xf_req} <= 6'h3f;
      mode <= 3'h3;
      wait_for(0);
      wait_for(1);
      chk(n, BW);
      chk({rst, rst_n, pfo_n, pz_oe_n, ce_n, sda_oe_n, chg.charge_en}, 7'h4e);
      chk({alm_o, tk, alm_en, xf_en, sw_m}, 5'h1e);
      chk({pz_o, xf_o}, 2'h1);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[8], 1'b1);
      $display("test backup done");
      mode <= 3'h1;
      wait_for(2);
      cyc(2);
      chk({bkp, sw_b}, 2'h0);
      chk({pz_o, pz_oe_n, sda, sda_oe_n, pfo_n, xf_o}, 6'h23);
      apb(1'b1, STATUS_OFFSET, 32'h100);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk(rd[8], 1'b0);
      $display("test return done");
      results();
   end
endmodule
